/* frontend_ctrl.sv */
// Functional notes
// - Resistor code 0 means integrator; codes 1-7 pick 1,2,3,5,7,10,15 Mohm.
// - Feedback capacitance is the five-bit code times 0.1 pF.
// - Amplifier powered down while enable bit is 0; enable resets to 0.
// - Auto bit powers the amplifier only during the integration window.
// - Offset field resets to 1, compensation field resets to 3, both read-write.
// - Front end one above high threshold (1824 down to 684 mV) raises clip.
// - Front end one below low threshold (76.2 up to 1216 mV) raises clip.
// - Front end two has its own thresholds and shares the clip flag.
// - Integration from sequencer normally, from software switch in manual mode.
// - LEDs, amplifier and converter run from register bits or the sequencer.
// - Sequencer windows are 8-bit counts on a prescaled 1 us base.
// - Each conversion result is stored without software help.
// - Sequencer timing applies only when manual mode is off.
// - Sequencer runs the programmed number of measurement cycles.
// - Writing 1 to start runs the sequencer, or in manual mode fires one conversion; writing 0 stops it.
// - LED and secondary LED windows open and close within each period.
// - Integrator window opens and closes within each period.
// - Four demodulator windows, positive and negative for two channels.
// - Converter sampled at a set position, plus optional second and third on the amplifier channel.
// - Programmable subsampling ratio with an always-subsample option.
// - Ultra-low-power suppresses LEDs and amplifier outside the sampled cycle.
// - A conversion requested while the converter is busy flags a timing error.
// - Manual-mode bit 7 at 0x2E selects sequencer at 0, manual at 1.
// - Time increment is divider plus one microseconds.
// - Count zero runs continuously until stopped.
`timescale 1ns/1ps
`default_nettype none
module frontend_ctrl
  import frontend_ctrl_pkg::*;
#(
  parameter int ADC_W = 16
)(
  input  wire logic        clock_i,
  input  wire logic        nrst_i,
  input  wire bus_req_t    bus_i,
  output logic [7:0]       rdata_o,
  input  wire logic [14:0] fe_one_level_i,
  input  wire logic [14:0] fe_two_level_i,
  input  wire logic        amp_channel_sel_i,
  input  wire logic        adc_busy_i,
  input  wire logic        adc_done_i,
  input  wire logic [ADC_W-1:0] adc_data_i,
  output amp_out_t         amp_o,
  output seq_out_t         seq_o,
  output logic             clip_irq_o,
  output logic             timing_error_irq_o,
  output logic             running_o
);

  if (ADC_W < 1 || ADC_W > 16) begin : g_bad_width
    $error("ADC_W must lie between 1 and 16");
  end

  // ==========================================================================
  // Reset release
  logic rst_meta_ff;
  logic rst_sync_ff;

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // ==========================================================================
  // State
  typedef struct packed {
    logic [7:0]                  amp_rc;
    logic [7:0]                  amp_mode;
    logic [7:0]                  clip_one;
    logic [7:0]                  clip_two;
    logic [7:0]                  manual;
    logic [1:0]                  manual_drive;
    logic [7:0]                  count;
    logic [7:0]                  divider;
    logic [7:0]                  period;
    logic [NUM_WINDOWS-1:0][7:0] win_open;
    logic [NUM_WINDOWS-1:0][7:0] win_close;
    logic [7:0]                  adc_pos;
    logic [1:0]                  adc_extra;
    logic [7:0]                  conv_cfg;
    logic                        running;
    logic [6:0]                  us_cnt;
    logic [7:0]                  prescale;
    logic [7:0]                  cycle_pos;
    logic [7:0]                  done_cnt;
    logic [3:0]                  subs_cnt;
    logic [NUM_WINDOWS-1:0]      win;
    logic                        adc_pulse;
    logic                        clip_flag;
    logic                        terr_flag;
    logic [15:0]                 result;
    logic [7:0]                  rdata;
  } state_t;

  state_t st_ff;
  state_t nxt_st;

  function automatic logic [14:0] high_level(input logic [3:0] code);
    high_level = 15'(HIGH_CLIP_TOP - 15'(CLIP_STEP * 15'(code)));
  endfunction

  function automatic logic [14:0] low_level(input logic [3:0] code);
    low_level = (code == 4'h0) ? LOW_CLIP_FIRST : 15'(CLIP_STEP * (15'(code) + 15'h0001));
  endfunction

  function automatic logic clipped(input logic [7:0] cfg, input logic [14:0] lvl);
    clipped = (lvl > high_level(cfg[7:4])) || (lvl < low_level(cfg[3:0]));
  endfunction

  // ==========================================================================
  // Combinational helpers
  logic       manual_mode;
  logic       tick_us;
  logic       inc;
  logic       wrap;
  logic [7:0] pos_n;
  logic       sd_active;
  logic       subs_on;
  logic       sample_cycle;
  logic       ulp_quiet;
  logic       conv_req;
  logic       start_wr;

  assign manual_mode = st_ff.manual[MANUAL_MODE_BIT];
  assign tick_us     = st_ff.running && (st_ff.us_cnt == US_LAST);
  assign inc         = tick_us && (st_ff.prescale == st_ff.divider);
  assign wrap        = (st_ff.period == 8'h00) ? (st_ff.cycle_pos == 8'hFF)
                                               : (st_ff.cycle_pos >= 8'(st_ff.period - 8'h01));
  assign pos_n       = wrap ? 8'h00 : 8'(st_ff.cycle_pos + 8'h01);
  assign sd_active   = |(st_ff.win_open[WIN_SDM2:WIN_SDP1] ^ st_ff.win_close[WIN_SDM2:WIN_SDP1]);
  assign subs_on      = (st_ff.conv_cfg[7:4] != 4'h0) && (st_ff.conv_cfg[PERSIST_BIT] || sd_active);
  assign sample_cycle = !subs_on || (st_ff.subs_cnt == 4'h0);
  // Quiet follows the sampled cycle, so an unsubsampled run never loses its pulses.
  // quiet cycles
  assign ulp_quiet    = !manual_mode && st_ff.conv_cfg[ULP_BIT] && !sample_cycle;
  assign start_wr     = bus_i.wr && (bus_i.addr == SEQ_START_OFS);
  assign conv_req     = inc && sample_cycle && !manual_mode &&
                        ((pos_n == st_ff.adc_pos) ||
                         (amp_channel_sel_i && st_ff.adc_extra[0]
                          && pos_n == 8'(st_ff.adc_pos + 8'h01)) ||
                         (amp_channel_sel_i && st_ff.adc_extra[1]
                          && pos_n == 8'(st_ff.adc_pos + 8'h02)));

  always_comb
  begin
    logic [7:0] widx;
    widx   = 8'(bus_i.addr - WINDOW_FIRST_OFS);
    nxt_st = st_ff;
    nxt_st.adc_pulse = 1'b0;

    // ========================================================================
    // Register writes
    if (bus_i.wr)
    begin
      unique case (bus_i.addr)
        AMP_FEEDBACK_RC_CONFIG_OFS: nxt_st.amp_rc = bus_i.wdata;
        AMP_MODE_CONFIG_OFS:        nxt_st.amp_mode = bus_i.wdata;
        FE_ONE_CLIP_OFS:            nxt_st.clip_one = bus_i.wdata;
        FE_TWO_CLIP_OFS:            nxt_st.clip_two = bus_i.wdata;
        MANUAL_CONTROL_OFS:         nxt_st.manual = bus_i.wdata;
        MANUAL_DRIVE_OFS:           nxt_st.manual_drive = bus_i.wdata[1:0];
        SEQ_COUNT_OFS:              nxt_st.count = bus_i.wdata;
        SEQ_DIVIDER_OFS:            nxt_st.divider = bus_i.wdata;
        SEQ_PERIOD_OFS:             nxt_st.period = bus_i.wdata;
        ADC_POSITION_OFS:           nxt_st.adc_pos = bus_i.wdata;
        ADC_EXTRA_OFS:              nxt_st.adc_extra = bus_i.wdata[1:0];
        CONVERTER_CONFIG_B_OFS:     nxt_st.conv_cfg = bus_i.wdata;
        default:
        begin
          if (bus_i.addr >= WINDOW_FIRST_OFS && bus_i.addr <= WINDOW_LAST_OFS)
          begin
            if (widx[0])
              nxt_st.win_close[widx[3:1]] = bus_i.wdata;
            else
              nxt_st.win_open[widx[3:1]] = bus_i.wdata;
          end
        end
      endcase
    end

    // ========================================================================
    // Sequencer
    if (st_ff.running)
    begin
      nxt_st.us_cnt = tick_us ? 7'h00 : 7'(st_ff.us_cnt + 7'h01);
      if (tick_us)
        nxt_st.prescale = inc ? 8'h00 : 8'(st_ff.prescale + 8'h01);
    end
    if (inc)
    begin
      nxt_st.cycle_pos = pos_n;
      for (int i = 0; i < NUM_WINDOWS; i++)
      begin
        if (pos_n == st_ff.win_close[i])
          nxt_st.win[i] = 1'b0;
        else if (pos_n == st_ff.win_open[i])
          nxt_st.win[i] = 1'b1;
      end
      if (wrap)
      begin
        nxt_st.done_cnt = 8'(st_ff.done_cnt + 8'h01);
        nxt_st.subs_cnt = (st_ff.subs_cnt >= st_ff.conv_cfg[7:4]) ? 4'h0
                                                                 : 4'(st_ff.subs_cnt + 4'h1);
        if (st_ff.count != 8'h00 && 8'(st_ff.done_cnt + 8'h01) == st_ff.count)
          nxt_st.running = 1'b0;
      end
    end
    nxt_st.adc_pulse = conv_req;

    if (start_wr)
    begin
      nxt_st.running   = bus_i.wdata[0] && !manual_mode;
      nxt_st.adc_pulse = bus_i.wdata[0] && manual_mode;
      nxt_st.us_cnt    = 7'h00;
      nxt_st.prescale  = 8'h00;
      nxt_st.cycle_pos = 8'h00;
      nxt_st.done_cnt  = 8'h00;
      nxt_st.subs_cnt  = 4'h0;
      nxt_st.win       = '0;
    end

    // ========================================================================
    // Event flags; a new event beats a same-cycle clear
    if (bus_i.wr && bus_i.addr == EVENT_STATUS_OFS)
    begin
      nxt_st.clip_flag = st_ff.clip_flag && !bus_i.wdata[CLIP_FLAG_BIT];
      nxt_st.terr_flag = st_ff.terr_flag && !bus_i.wdata[TERR_FLAG_BIT];
    end
    // front end one, high and low side, front end two
    if (clipped(st_ff.clip_one, fe_one_level_i) || clipped(st_ff.clip_two, fe_two_level_i))
      nxt_st.clip_flag = 1'b1;
    if (nxt_st.adc_pulse && adc_busy_i)
      nxt_st.terr_flag = 1'b1;

    if (adc_done_i)
      nxt_st.result = 16'(adc_data_i);

    // ========================================================================
    // Register reads
    nxt_st.rdata = 8'h00;
    if (bus_i.rd)
    begin
      unique case (bus_i.addr)
        AMP_FEEDBACK_RC_CONFIG_OFS: nxt_st.rdata = st_ff.amp_rc;
        AMP_MODE_CONFIG_OFS:        nxt_st.rdata = st_ff.amp_mode;
        FE_ONE_CLIP_OFS:            nxt_st.rdata = st_ff.clip_one;
        FE_TWO_CLIP_OFS:            nxt_st.rdata = st_ff.clip_two;
        MANUAL_CONTROL_OFS:         nxt_st.rdata = st_ff.manual;
        MANUAL_DRIVE_OFS:           nxt_st.rdata = {6'h00, st_ff.manual_drive};
        SEQ_COUNT_OFS:              nxt_st.rdata = st_ff.count;
        SEQ_DIVIDER_OFS:            nxt_st.rdata = st_ff.divider;
        SEQ_START_OFS:              nxt_st.rdata = {7'h00, st_ff.running};
        SEQ_PERIOD_OFS:             nxt_st.rdata = st_ff.period;
        ADC_POSITION_OFS:           nxt_st.rdata = st_ff.adc_pos;
        ADC_EXTRA_OFS:              nxt_st.rdata = {6'h00, st_ff.adc_extra};
        CONVERTER_CONFIG_B_OFS:     nxt_st.rdata = st_ff.conv_cfg;
        EVENT_STATUS_OFS:           nxt_st.rdata = {6'h00, st_ff.terr_flag, st_ff.clip_flag};
        RESULT_LOW_OFS:             nxt_st.rdata = st_ff.result[7:0];
        RESULT_HIGH_OFS:            nxt_st.rdata = st_ff.result[15:8];
        default:
        begin
          if (bus_i.addr >= WINDOW_FIRST_OFS && bus_i.addr <= WINDOW_LAST_OFS)
            nxt_st.rdata = widx[0] ? st_ff.win_close[widx[3:1]] : st_ff.win_open[widx[3:1]];
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      st_ff          <= '0;
      // enable resets low, offset 1 and compensation 3
      st_ff.amp_mode <= AMP_MODE_RESET;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================================
  // Outputs
  logic integrate_now;

  // integration source, timing ignored in manual mode
  assign integrate_now = manual_mode ? st_ff.manual[MAN_ITG_BIT] : st_ff.win[WIN_ITG];

  always_comb
  begin
    amp_o.resistor_sel    = 8'(8'h01 << st_ff.amp_rc[7:5]);
    amp_o.integrator_mode = (st_ff.amp_rc[7:5] == 3'h0);
    // 0.1 pF per step, shown in femtofarads
    amp_o.capacitor_ff    = 12'(CAP_FF_STEP * 12'(st_ff.amp_rc[4:0]));
    amp_o.offset_code       = st_ff.amp_mode[5:2];
    amp_o.compensation_code = st_ff.amp_mode[1:0];
    // power gate, auto power, quiet cycles
    amp_o.power = st_ff.amp_mode[AMP_ENABLE_BIT] && !ulp_quiet
                  && (!st_ff.amp_mode[AMP_AUTO_BIT] || integrate_now);
    if (manual_mode)
    begin
      seq_o.led        = st_ff.manual_drive[0];
      seq_o.secled     = st_ff.manual_drive[1];
      seq_o.demod1_pos = st_ff.manual[MAN_MULT_BIT] && st_ff.manual[MAN_POL_BIT];
      seq_o.demod1_neg = st_ff.manual[MAN_MULT_BIT] && !st_ff.manual[MAN_POL_BIT];
      seq_o.demod2_pos = seq_o.demod1_pos;
      seq_o.demod2_neg = seq_o.demod1_neg;
    end
    else
    begin
      seq_o.led        = st_ff.win[WIN_LED] && !ulp_quiet;
      seq_o.secled     = st_ff.win[WIN_SECLED] && !ulp_quiet;
      seq_o.demod1_pos = st_ff.win[WIN_SDP1];
      seq_o.demod1_neg = st_ff.win[WIN_SDM1];
      seq_o.demod2_pos = st_ff.win[WIN_SDP2];
      seq_o.demod2_neg = st_ff.win[WIN_SDM2];
    end
    seq_o.integrate  = integrate_now;
    seq_o.adc_sample = st_ff.adc_pulse;
  end

  assign rdata_o            = st_ff.rdata;
  assign clip_irq_o         = st_ff.clip_flag;
  assign timing_error_irq_o = st_ff.terr_flag;
  assign running_o          = st_ff.running;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_sync_ff);

  amp_power_down_a: assert property (!st_ff.amp_mode[AMP_ENABLE_BIT] |-> !amp_o.power)
    else $error("amplifier powered while disabled");
  amp_auto_gate_a: assert property (amp_o.power && st_ff.amp_mode[AMP_AUTO_BIT]
                                    |-> seq_o.integrate)
    else $error("auto amplifier powered outside integration");
  resistor_zero_a: assert property (amp_o.integrator_mode |-> amp_o.resistor_sel == 8'h01)
    else $error("integrator mode with resistor selected");
  cap_scale_a: assert property (st_ff.amp_rc[4:0] == 5'h1F |-> amp_o.capacitor_ff == 12'hC1C)
    else $error("feedback capacitance scale wrong");
  manual_itg_a: assert property (manual_mode |-> seq_o.integrate == st_ff.manual[MAN_ITG_BIT])
    else $error("manual integrator switch ignored");
  clip_one_a: assert property (fe_one_level_i > high_level(st_ff.clip_one[7:4])
                               |=> clip_irq_o)
    else $error("high clip missed");
  clip_two_a: assert property (fe_two_level_i < low_level(st_ff.clip_two[3:0])
                               |=> clip_irq_o)
    else $error("second front end clip missed");
  stop_write_a: assert property (start_wr && !bus_i.wdata[0] |=> !running_o)
    else $error("sequencer did not stop");
  manual_no_seq_a: assert property (manual_mode |=> !$rose(running_o))
    else $error("sequencer started in manual mode");
  count_end_a: assert property ($fell(running_o) && !$past(start_wr)
                                |-> $past(st_ff.count) != 8'h00)
    else $error("continuous sequence stopped by itself");
  busy_error_a: assert property (seq_o.adc_sample && $past(adc_busy_i) |-> timing_error_irq_o)
    else $error("timing error not flagged");
  ulp_quiet_a: assert property (ulp_quiet |-> !seq_o.led && !amp_o.power)
    else $error("pulses not suppressed in quiet cycle");
  inc_spacing_a: assert property (inc |=> !inc [*8])
    else $error("time increments too close");

  run_cover_c: cover property ($rose(running_o));
  sample_cover_c: cover property (seq_o.adc_sample && !manual_mode);
  clip_cover_c: cover property ($rose(clip_irq_o));

endmodule
`default_nettype wire

/* frontend_ctrl_pkg.sv */
`default_nettype none
package frontend_ctrl_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] AMP_FEEDBACK_RC_CONFIG_OFS = 8'h1D;
  localparam logic [7:0] AMP_MODE_CONFIG_OFS        = 8'h1E;
  localparam logic [7:0] FE_ONE_CLIP_OFS            = 8'h1F;
  localparam logic [7:0] MANUAL_CONTROL_OFS         = 8'h2E;
  localparam logic [7:0] SEQ_COUNT_OFS              = 8'h30;
  localparam logic [7:0] SEQ_DIVIDER_OFS            = 8'h31;
  localparam logic [7:0] SEQ_START_OFS              = 8'h32;
  localparam logic [7:0] SEQ_PERIOD_OFS             = 8'h33;
  localparam logic [7:0] WINDOW_FIRST_OFS           = 8'h34;
  localparam logic [7:0] WINDOW_LAST_OFS            = 8'h41;
  localparam logic [7:0] ADC_POSITION_OFS           = 8'h42;
  localparam logic [7:0] ADC_EXTRA_OFS              = 8'h43;
  localparam logic [7:0] CONVERTER_CONFIG_B_OFS     = 8'h44;
  localparam logic [7:0] EVENT_STATUS_OFS           = 8'h45;
  localparam logic [7:0] MANUAL_DRIVE_OFS           = 8'h47;
  localparam logic [7:0] RESULT_LOW_OFS             = 8'h48;
  localparam logic [7:0] RESULT_HIGH_OFS            = 8'h49;
  localparam logic [7:0] FE_TWO_CLIP_OFS            = 8'h56;

  // ==========================================================================
  // Field positions and reset values
  localparam int AMP_ENABLE_BIT  = 7;
  localparam int AMP_AUTO_BIT    = 6;
  localparam int MANUAL_MODE_BIT = 7;
  localparam int MAN_MULT_BIT    = 6;
  localparam int MAN_POL_BIT     = 5;
  localparam int MAN_ITG_BIT     = 4;
  localparam int ULP_BIT         = 1;
  localparam int PERSIST_BIT     = 0;
  localparam int CLIP_FLAG_BIT   = 0;
  localparam int TERR_FLAG_BIT   = 1;
  localparam logic [7:0] AMP_MODE_RESET = 8'h07;

  // ==========================================================================
  // Window indices and timing
  localparam int NUM_WINDOWS = 7;
  localparam int WIN_LED     = 0;
  localparam int WIN_SECLED  = 1;
  localparam int WIN_ITG     = 2;
  localparam int WIN_SDP1    = 3;
  localparam int WIN_SDP2    = 4;
  localparam int WIN_SDM1    = 5;
  localparam int WIN_SDM2    = 6;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TIME_BASE_NS  = 1000;
  localparam int CYC_PER_US    = TIME_BASE_NS / CLK_PERIOD_NS;
  localparam logic [6:0] US_LAST = 7'(CYC_PER_US - 1);
  // Clip levels are in units of 0.1 mV.
  localparam logic [14:0] HIGH_CLIP_TOP  = 15'h4740;
  localparam logic [14:0] CLIP_STEP      = 15'h02F8;
  localparam logic [14:0] LOW_CLIP_FIRST = 15'h02FA;
  localparam logic [11:0] CAP_FF_STEP    = 12'h064;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_t;

  typedef struct packed {
    logic        power;
    logic        integrator_mode;
    logic [7:0]  resistor_sel;
    logic [11:0] capacitor_ff;
    logic [3:0]  offset_code;
    logic [1:0]  compensation_code;
  } amp_out_t;

  typedef struct packed {
    logic led;
    logic secled;
    logic integrate;
    logic demod1_pos;
    logic demod1_neg;
    logic demod2_pos;
    logic demod2_neg;
    logic adc_sample;
  } seq_out_t;

endpackage
`default_nettype wire

/* test_optical_frontend_amp_and_sequencer_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) \
  begin check_count++; if ((got) !== (exp)) begin miscompares++; \
  $display("unexpected %s expected %0h seen %0h", nm, exp, got); end end
module test_optical_frontend_amp_and_sequencer_ctrl import frontend_ctrl_pkg::*;;
  logic        clock_i;
  logic        nrst_i;
  bus_req_t    bus;
  logic [7:0]  rdata;
  logic [14:0] lvl1;
  logic [14:0] lvl2;
  logic        busy;
  logic        chan;
  logic        done;
  logic [15:0] adata;
  amp_out_t    amp;
  seq_out_t    seq;
  logic        clip;
  logic        terr;
  logic        running;
  int          miscompares;
  int          check_count;
  int          pulses;
  int          leds;
  int          p0;
  int          n;
  int          m;
  logic [7:0]  v;

  frontend_ctrl DUT (.clock_i(clock_i), .nrst_i(nrst_i), .bus_i(bus), .rdata_o(rdata),
    .fe_one_level_i(lvl1), .fe_two_level_i(lvl2), .amp_channel_sel_i(chan),
    .adc_busy_i(busy), .adc_done_i(done), .adc_data_i(adata), .amp_o(amp), .seq_o(seq),
    .clip_irq_o(clip), .timing_error_irq_o(terr), .running_o(running));

  initial
  begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  // Counted on every rising edge so that single-cycle pulses are never missed.
  always @(posedge clock_i)
  begin
    if (seq.adc_sample === 1'b1)
      pulses++;
    if (seq.led === 1'b1)
      leds++;
  end

  // ==========================================================================
  // Bus and helper tasks
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock_i);
    bus.wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock_i);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock_i);
    bus.rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic set_lvl(input logic [14:0] a, input logic [14:0] b);
    @(posedge clock_i);
    lvl1 <= a;
    lvl2 <= b;
    repeat (3) @(posedge clock_i);
    #1;
  endtask

  task automatic wait_for(input int sel, input logic lvl, output int cnt);
    cnt = 0;
    while (((sel == 0) ? seq.led : running) !== lvl && cnt < 1000)
    begin
      @(posedge clock_i);
      #1;
      cnt++;
    end
    if (cnt >= 1000)
    begin
      miscompares++;
      test_done;
    end
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial
  begin
    nrst_i = 1'b0;
    bus = '0;
    lvl1 = 15'd5000;
    lvl2 = 15'd13000;
    busy = 1'b0;
    pulses = 0;
    leds = 0;
    chan = 1'b0;
    done = 1'b0;
    adata = 16'h0000;
    repeat (8) @(posedge clock_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    rd(AMP_MODE_CONFIG_OFS, v);
    `CHK("amp_mode_reset", 8'h07, v)
    `CHK("power_reset", 1'b0, amp.power)
    `CHK("offset_reset", 4'h1, amp.offset_code)
    `CHK("comp_reset", 2'h3, amp.compensation_code)
    rd(8'h00, v);
    `CHK("unmapped", 8'h00, v)
    $display("test reset done");
    for (int c = 0; c < 8; c++)
    begin
      wr(AMP_FEEDBACK_RC_CONFIG_OFS, {3'(c), 5'(c + 3)});
      `CHK("resistor_sel", 8'(8'h01 << c), amp.resistor_sel)
      `CHK("integrator", 1'(c == 0), amp.integrator_mode)
      `CHK("cap_ff", 12'(100 * (c + 3)), amp.capacitor_ff)
      rd(AMP_FEEDBACK_RC_CONFIG_OFS, v);
      `CHK("rc_readback", {3'(c), 5'(c + 3)}, v)
    end
    wr(AMP_MODE_CONFIG_OFS, 8'h87);
    `CHK("power_on", 1'b1, amp.power)
    wr(AMP_MODE_CONFIG_OFS, 8'h9A);
    `CHK("offset_rw", 4'h6, amp.offset_code)
    `CHK("comp_rw", 2'h2, amp.compensation_code)
    wr(AMP_MODE_CONFIG_OFS, 8'hC7);
    `CHK("power_auto_idle", 1'b0, amp.power)
    $display("test amplifier done");
    wr(FE_ONE_CLIP_OFS, 8'hF0);
    set_lvl(15'd6840, 15'd13000);
    `CHK("clip_at_high", 1'b0, clip)
    set_lvl(15'd6841, 15'd13000);
    `CHK("clip_above_high", 1'b1, clip)
    set_lvl(15'd762, 15'd13000);
    wr(EVENT_STATUS_OFS, 8'h01);
    `CHK("clip_cleared", 1'b0, clip)
    set_lvl(15'd761, 15'd13000);
    `CHK("clip_below_low", 1'b1, clip)
    set_lvl(15'd5000, 15'd13000);
    wr(FE_TWO_CLIP_OFS, 8'h0F);
    wr(EVENT_STATUS_OFS, 8'h01);
    `CHK("clip_recleared", 1'b0, clip)
    set_lvl(15'd5000, 15'd12160);
    `CHK("clip_two_at_low", 1'b0, clip)
    set_lvl(15'd5000, 15'd12159);
    `CHK("clip_two_below", 1'b1, clip)
    set_lvl(15'd5000, 15'd13000);
    $display("test clip done");
    wr(MANUAL_CONTROL_OFS, 8'hF0);
    `CHK("manual_itg", 1'b1, seq.integrate)
    `CHK("manual_demod", 1'b1, seq.demod1_pos)
    wr(MANUAL_DRIVE_OFS, 8'h03);
    `CHK("manual_led", 1'b1, seq.led)
    `CHK("manual_secled", 1'b1, seq.secled)
    p0 = pulses;
    wr(SEQ_START_OFS, 8'h01);
    repeat (2) @(posedge clock_i);
    #1;
    `CHK("manual_running", 1'b0, running)
    `CHK("manual_adc", 1, pulses - p0)
    wr(MANUAL_CONTROL_OFS, 8'h00);
    `CHK("seq_itg_idle", 1'b0, seq.integrate)
    $display("test manual done");
    wr(SEQ_PERIOD_OFS, 8'h04);
    wr(8'h34, 8'h01);
    wr(8'h35, 8'h03);
    wr(8'h38, 8'h01);
    wr(8'h39, 8'h03);
    wr(AMP_FEEDBACK_RC_CONFIG_OFS, 8'h2D);
    wr(8'h3A, 8'h01);
    wr(8'h3B, 8'h03);
    wr(SEQ_COUNT_OFS, 8'h01);
    wr(ADC_POSITION_OFS, 8'h02);
    for (int d = 0; d < 2; d++)
    begin
      wr(SEQ_DIVIDER_OFS, 8'(d));
      busy <= (d == 1);
      p0 = pulses;
      wr(SEQ_START_OFS, 8'h01);
      @(posedge clock_i);
      #1;
      `CHK("running", 1'b1, running)
      wait_for(0, 1'b1, n);
      `CHK("led_open", 1'b1, 1'(n >= 97 * (d + 1) && n <= 103 * (d + 1)))
      `CHK("auto_power", 1'b1, amp.power)
      `CHK("itg_open", 1'b1, seq.integrate)
      `CHK("demod_open", 1'b1, seq.demod1_pos)
      wait_for(0, 1'b0, m);
      `CHK("led_width", 1'b1, 1'(m >= 197 * (d + 1) && m <= 203 * (d + 1)))
      wait_for(1, 1'b0, n);
      `CHK("count_done", 1'b1, 1'(n <= 105 * (d + 1)))
      `CHK("adc_pulses", 1, pulses - p0)
    end
    `CHK("timing_error", 1'b1, terr)
    busy <= 1'b0;
    $display("test sequencer done");
    // Extra conversions on the amplifier channel, then quiet subsampled cycles.
    chan <= 1'b1;
    wr(SEQ_DIVIDER_OFS, 8'h00);
    wr(ADC_POSITION_OFS, 8'h01);
    wr(ADC_EXTRA_OFS, 8'h03);
    p0 = pulses;
    wr(SEQ_START_OFS, 8'h01);
    wait_for(1, 1'b0, n);
    `CHK("extra_conv", 3, pulses - p0)
    chan <= 1'b0;
    wr(SEQ_COUNT_OFS, 8'h02);
    wr(CONVERTER_CONFIG_B_OFS, 8'h13);
    p0 = pulses;
    m = leds;
    wr(SEQ_START_OFS, 8'h01);
    wait_for(1, 1'b0, n);
    `CHK("subsampled", 1, pulses - p0)
    `CHK("ulp_led_cycles", 200, leds - m)
    @(posedge clock_i);
    adata <= 16'hA5C3;
    done <= 1'b1;
    @(posedge clock_i);
    done <= 1'b0;
    rd(RESULT_LOW_OFS, v);
    `CHK("result_low", 8'hC3, v)
    rd(RESULT_HIGH_OFS, v);
    `CHK("result_high", 8'hA5, v)
    $display("test conversions done");
    wr(SEQ_DIVIDER_OFS, 8'h00);
    wr(SEQ_COUNT_OFS, 8'h00);
    wr(SEQ_START_OFS, 8'h01);
    repeat (900) @(posedge clock_i);
    #1;
    `CHK("continuous", 1'b1, running)
    wr(SEQ_START_OFS, 8'h00);
    @(posedge clock_i);
    #1;
    `CHK("stopped", 1'b0, running)
    $display("test continuous done");
    test_done;
  end
endmodule
`default_nettype wire
